// >>> rtl/input_signal_loss_monitor.sv
// Functional notes
// - count fifo, signal-loss and clock error events
// - mask bit 4 stops clock error counting
// - mask bit 3 stops fifo error counting
// - mask bit 2 stops clock-detect error counting
// - mask bit 1 stops clock-loss error counting
// - mask bit 0 stops data-loss counting
// - override bit 1 forces indicator low
// - override bit 0 forces high, wins
// - status bit 5 high when clock absent
// - status bits 4:0 high per absent lane
// - status read-only, six bits, resets zero
`timescale 1ns/1ns
`default_nettype none
`include "ism_map.svh"

module input_signal_loss_monitor #(
    parameter int LANES           = 5,
    parameter int COUNT_W         = 8,
    parameter int CLK_ABSENT_CYC  = `ISM_CLK_ABSENT_CYC,
    parameter int DATA_ABSENT_CYC = `ISM_DATA_ABSENT_CYC
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    // ahb-lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic [31:0]           hrdata,
    output logic                  hresp,
    // link side
    input  wire logic             input_clock_pair,
    input  wire logic [LANES-1:0] data_lanes,
    // same-clock error pulses from the datapath
    input  wire logic             fifo_error,
    input  wire logic             pll_clock_error,
    input  wire logic             clock_detect_error,
    // status outputs
    output logic                  signal_missing_indicator,
    output logic                  irq
);

    localparam int NIN = LANES + 1;
    localparam int NEV = `ISM_EV_NUM;
    localparam int TW  = 16;
    // counter window base, only its upper bits are compared
    localparam logic [9:0] CNT_BASE = `ISM_ADDR_CNT_BASE;

    // address decode, used for both write and read
    function automatic ism_pkg::reg_sel_t decode(input logic [9:0] a);
        ism_pkg::reg_sel_t s;
        s = ism_pkg::SEL_NONE;
        if (a == {`ISM_IDX_EMASK, 2'b00}) begin
            s = ism_pkg::SEL_EMASK;
        end else if (a == {`ISM_IDX_OVR, 2'b00}) begin
            s = ism_pkg::SEL_OVR;
        end else if (a == {`ISM_IDX_STAT, 2'b00}) begin
            s = ism_pkg::SEL_STAT;
        end else if (a == `ISM_ADDR_IST) begin
            s = ism_pkg::SEL_IST;
        end else if (a == `ISM_ADDR_IMASK) begin
            s = ism_pkg::SEL_IMASK;
        end else if (a[9:5] == CNT_BASE[9:5] && a[1:0] == 2'b00
                     && int'(a[4:2]) < NEV) begin
            s = ism_pkg::SEL_CNT;
        end
        return s;
    endfunction : decode

    // ---------------------------------------------------------------
    // link input synchroniser, top bit is the clock pair
    logic [NIN-1:0] meta_q;
    logic [NIN-1:0] sync_q;
    logic [NIN-1:0] prev_q;
    wire  [NIN-1:0] raw_in = {input_clock_pair, data_lanes};
    wire  [NIN-1:0] toggle = sync_q ^ prev_q;

    // two flops, then an edge history flop
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // ---------------------------------------------------------------
    // absence timers, one per input
    wire  [NIN-1:0] absent_q;
    logic [NIN-1:0] absent_prev_q;

    generate
        for (genvar i = 0; i < NIN; i++) begin : g_timer
            localparam int LIM = (i == LANES) ? CLK_ABSENT_CYC : DATA_ABSENT_CYC;
            localparam logic [TW-1:0] LIM_C = TW'(LIM - 1);
            logic [TW-1:0] cnt_q;
            logic          gone_q;
            wire           expired = (cnt_q == LIM_C);

            // each timer owns its flag, the vector only collects them
            assign absent_q[i] = gone_q;

            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    cnt_q  <= '0;
                    gone_q <= 1'b0;
                end else if (toggle[i]) begin
                    cnt_q  <= '0;
                    gone_q <= 1'b0;
                end else if (expired) begin
                    gone_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + TW'(1);
                end
            end
        end
    endgenerate

    // history for onset of absence
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            absent_prev_q <= '0;
        end else begin
            absent_prev_q <= absent_q;
        end
    end

    // ---------------------------------------------------------------
    // software registers
    logic [NEV-1:0] emask_q;
    logic [1:0]     ovr_q;
    logic [NEV-1:0] ist_q;
    logic [NEV-1:0] imask_q;

    wire force_high = ovr_q[`ISM_OVR_HIGH];
    wire force_low  = ovr_q[`ISM_OVR_LOW];

    wire [NIN-1:0] status_view = force_high ? {NIN{1'b1}} :
                                 force_low  ? {NIN{1'b0}} : absent_q;

    // indicator from a flop
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            signal_missing_indicator <= 1'b0;
        end else begin
            signal_missing_indicator <= |status_view;
        end
    end

    // ---------------------------------------------------------------
    // event sources and masking
    wire [NIN-1:0] absent_rise = absent_q & ~absent_prev_q;
    logic [NEV-1:0] events;

    always_comb begin
        events                 = '0;
        events[`ISM_EV_DATA]   = |absent_rise[LANES-1:0];
        events[`ISM_EV_CLKLOS] = absent_rise[LANES];
        events[`ISM_EV_DETECT] = clock_detect_error;
        events[`ISM_EV_FIFO]   = fifo_error;
        events[`ISM_EV_CLOCK]  = pll_clock_error;
    end

    wire [NEV-1:0] counted = events & ~emask_q;

    // ---------------------------------------------------------------
    // ahb-lite address and data phase
    ism_pkg::addr_phase_t ap_q;
    logic                 rd_done_q;
    logic [31:0]          hrdata_q;

    wire take = hsel & htrans[1] & hready;
    wire wr   = ap_q.valid & ap_q.write;
    wire rd   = ap_q.valid & ~ap_q.write;
    wire ism_pkg::reg_sel_t wsel = decode(ap_q.addr);
    wire [2:0] cidx = ap_q.addr[4:2];

    // reads wait one cycle so a preceding write is seen
    assign hreadyout = ~(rd & ~rd_done_q);
    assign hrdata    = hrdata_q;
    assign hresp     = 1'b0;

    // address phase capture
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ap_q <= '0;
        end else if (hready) begin
            ap_q.valid <= take;
            ap_q.write <= hwrite;
            ap_q.addr  <= haddr[9:0];
        end
    end

    // read wait tracking
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_done_q <= 1'b0;
        end else if (hready) begin
            rd_done_q <= 1'b0;
        end else if (rd) begin
            rd_done_q <= 1'b1;
        end
    end

    wire wr_emask = wr & (wsel == ism_pkg::SEL_EMASK);
    wire wr_ovr   = wr & (wsel == ism_pkg::SEL_OVR);
    wire wr_ist   = wr & (wsel == ism_pkg::SEL_IST);
    wire wr_imask = wr & (wsel == ism_pkg::SEL_IMASK);
    wire wr_cnt   = wr & (wsel == ism_pkg::SEL_CNT);

    // control registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            emask_q <= `ISM_RST_EMASK;
            ovr_q   <= `ISM_RST_OVR;
            imask_q <= `ISM_RST_IMASK;
        end else begin
            if (wr_emask) emask_q <= hwdata[NEV-1:0];
            if (wr_ovr)   ovr_q   <= hwdata[1:0];
            if (wr_imask) imask_q <= hwdata[NEV-1:0];
        end
    end

    // sticky status, write one clears, a new event wins
    wire [NEV-1:0] ist_clr = wr_ist ? hwdata[NEV-1:0] : '0;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ist_q <= '0;
        end else begin
            ist_q <= (ist_q & ~ist_clr) | counted;
        end
    end

    assign irq = |(ist_q & imask_q);

    // ---------------------------------------------------------------
    // event counters, saturating, a write of any value to a counter clears it, or loads 1 if its event is counted in that cycle
    wire [COUNT_W-1:0] cnt_q [NEV];

    generate
        for (genvar k = 0; k < NEV; k++) begin : g_count
            logic [COUNT_W-1:0] val_q;
            wire                clr = wr_cnt & (int'(cidx) == k);
            wire                sat = &val_q;

            // one process per counter, the array is only a view
            assign cnt_q[k] = val_q;

            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    val_q <= '0;
                end else if (clr) begin
                    val_q <= {{(COUNT_W-1){1'b0}}, counted[k]};
                end else if (counted[k] && !sat) begin
                    val_q <= val_q + COUNT_W'(1);
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // read mux
    logic [31:0] rmux;

    always_comb begin
        rmux = '0;
        unique case (wsel)
            ism_pkg::SEL_EMASK: rmux[NEV-1:0] = emask_q;
            ism_pkg::SEL_OVR:   rmux[1:0]     = ovr_q;
            ism_pkg::SEL_STAT:  rmux[NIN-1:0] = status_view;
            ism_pkg::SEL_IST:   rmux[NEV-1:0] = ist_q;
            ism_pkg::SEL_IMASK: rmux[NEV-1:0] = imask_q;
            ism_pkg::SEL_CNT:   rmux[COUNT_W-1:0] = cnt_q[cidx];
            ism_pkg::SEL_NONE:  rmux = '0;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hrdata_q <= '0;
        end else if (rd && !rd_done_q) begin
            hrdata_q <= rmux;
        end
    end

endmodule : input_signal_loss_monitor
`default_nettype wire

// >>> rtl/ism_map.svh
`ifndef ISM_MAP_SVH
`define ISM_MAP_SVH

// register indices, byte address is four times the index
`define ISM_IDX_EMASK      8'h27
`define ISM_IDX_OVR        8'h28
`define ISM_IDX_STAT       8'h29
// own registers, byte addresses
`define ISM_ADDR_CNT_BASE  10'h000
`define ISM_ADDR_IST       10'h020
`define ISM_ADDR_IMASK     10'h024

// event classes, same positions as error_count_mask bits
`define ISM_EV_DATA        0
`define ISM_EV_CLKLOS      1
`define ISM_EV_DETECT      2
`define ISM_EV_FIFO        3
`define ISM_EV_CLOCK       4
`define ISM_EV_NUM         5

// signal_loss_override fields
`define ISM_OVR_HIGH       0
`define ISM_OVR_LOW        1
// signal_loss_status clock flag position
`define ISM_STAT_CLK       5

// reset values
`define ISM_RST_EMASK      5'h00
`define ISM_RST_OVR        2'h0
`define ISM_RST_IMASK      5'h00

// timing
`define ISM_CLK_PERIOD_NS  4
`define ISM_CLK_ABSENT_NS  256
`define ISM_DATA_ABSENT_NS 1024
`define ISM_CLK_ABSENT_CYC \
    ((`ISM_CLK_ABSENT_NS + `ISM_CLK_PERIOD_NS - 1) / `ISM_CLK_PERIOD_NS)
`define ISM_DATA_ABSENT_CYC \
    ((`ISM_DATA_ABSENT_NS + `ISM_CLK_PERIOD_NS - 1) / `ISM_CLK_PERIOD_NS)

`endif

// >>> rtl/ism_pkg.sv
package ism_pkg;

    // captured ahb address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [9:0] addr;
    } addr_phase_t;

    // register selected by an address
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_EMASK,
        SEL_OVR,
        SEL_STAT,
        SEL_IST,
        SEL_IMASK,
        SEL_CNT
    } reg_sel_t;

endpackage : ism_pkg

// >>> tb/input_signal_loss_monitor_test.sv
`timescale 1ns/1ns
`default_nettype none
module input_signal_loss_monitor_test;
    localparam int CA = 16;
    localparam int DA = 32;
    typedef struct {logic [31:0] a; logic [31:0] w; logic [31:0] e;} row_t;
    logic        clock, rstn, hsel, hwrite, hreadyout, hresp, ind, irq;
    logic        link_clk, run_clk;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [4:0]  lanes, run_lanes, ev_q;
    logic [31:0] haddr, hwdata, hrdata, x;
    wire         hready;
    int          n_errors = 0;
    int          checks_done = 0;
    row_t rows[5] = '{'{32'h9C, 32'hFFFFFFFF, 32'h1F}, '{32'hA0, 32'hFFFFFFFC, 32'h0},
        '{32'hA4, 32'hFFFFFFFF, 32'h0}, '{32'h300, 32'hFFFFFFFF, 32'h0},
        '{32'h9C, 32'h0, 32'h0}};
    assign hready = hreadyout;
    input_signal_loss_monitor #(.CLK_ABSENT_CYC(CA), .DATA_ABSENT_CYC(DA)) dut (
        .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .input_clock_pair(link_clk), .data_lanes(lanes), .fifo_error(ev_q[3]),
        .pll_clock_error(ev_q[4]), .clock_detect_error(ev_q[2]),
        .signal_missing_indicator(ind), .irq(irq));
    ism_link_model link (.run_clk(run_clk), .run_lanes(run_lanes),
        .link_clk(link_clk), .lanes(lanes));
    task tally_and_finish;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(negedge clock);
        while (hreadyout !== 1'b1) @(negedge clock);
        @(posedge clock);
        htrans <= 2'h0;
        hwdata <= wd;
        @(negedge clock);
        while (hreadyout !== 1'b1) @(negedge clock);
        x = hrdata;
        @(posedge clock);
    endtask : xfer
    task rdc(input logic [31:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(x, e);
    endtask : rdc
    task pins(input logic [1:0] e);
        @(negedge clock);
        chk({30'h0, ind, irq}, {30'h0, e});
        @(posedge clock);
    endtask : pins
    task pulse(input int k, input int n);
        ev_q[k] <= 1'b1;
        repeat (n) @(posedge clock);
        ev_q[k] <= 1'b0;
        @(posedge clock);
    endtask : pulse
    // clock and timeout
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        #40000;
        n_errors++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, ev_q, rstn} = '0;
        hsize = 3'h2;
        run_clk = 1'b1;
        run_lanes = 5'h1F;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        foreach (rows[i]) rdc(rows[i].a, 32'h0);
        pins(2'h0);
        foreach (rows[i]) begin
            xfer(rows[i].a, 1'b1, rows[i].w);
            rdc(rows[i].a, rows[i].e);
        end
        for (int i = 1; i < 4; i++) begin
            xfer(32'hA0, 1'b1, 32'(i ^ 2));
            rdc(32'hA4, (i ^ 2) & 1 ? 32'h3F : 32'h0);
            pins({1'((i ^ 2) & 1), 1'b0});
        end
        xfer(32'hA0, 1'b1, 32'h0);
        xfer(32'h24, 1'b1, 32'h1F);
        run_clk <= 1'b0;
        repeat (CA + 12) @(posedge clock);
        repeat (2) rdc(32'hA4, 32'h20);
        rdc(32'h04, 32'h1);
        pins(2'h3);
        xfer(32'h20, 1'b1, 32'h1F);
        pins(2'h2);
        xfer(32'hA0, 1'b1, 32'h2);
        rdc(32'hA4, 32'h0);
        pins(2'h0);
        xfer(32'hA0, 1'b1, 32'h0);
        run_clk <= 1'b1;
        repeat (20) @(posedge clock);
        rdc(32'hA4, 32'h0);
        xfer(32'h9C, 1'b1, 32'h2);
        xfer(32'h04, 1'b1, 32'h0);
        run_clk <= 1'b0;
        repeat (CA + 12) @(posedge clock);
        rdc(32'h04, 32'h0);
        run_clk <= 1'b1;
        xfer(32'h9C, 1'b1, 32'h0);
        run_lanes <= 5'h17;
        repeat (DA + 12) @(posedge clock);
        rdc(32'hA4, 32'h08);
        rdc(32'h00, 32'h1);
        xfer(32'h9C, 1'b1, 32'h1);
        xfer(32'h00, 1'b1, 32'h0);
        run_lanes <= 5'h1F;
        repeat (20) @(posedge clock);
        run_lanes <= 5'h0F;
        repeat (DA + 12) @(posedge clock);
        rdc(32'hA4, 32'h10);
        rdc(32'h00, 32'h0);
        run_lanes <= 5'h1F;
        repeat (20) @(posedge clock);
        xfer(32'h20, 1'b1, 32'h1F);
        xfer(32'h24, 1'b1, 32'h0);
        for (int k = 2; k < 5; k++) begin
            xfer(32'h9C, 1'b1, 32'h0);
            xfer(32'(4 * k), 1'b1, 32'h0);
            pulse(k, 3);
            xfer(32'h9C, 1'b1, 32'(1 << k));
            pulse(k, 2);
            rdc(32'(4 * k), 32'h3);
        end
        rdc(32'h20, 32'h1C);
        pins(2'h0);
        xfer(32'h24, 1'b1, 32'h1C);
        pins(2'h1);
        xfer(32'h20, 1'b1, 32'h1C);
        pins(2'h0);
        // mid-run reset with registers set
        xfer(32'h9C, 1'b1, 32'h15);
        xfer(32'hA0, 1'b1, 32'h1);
        rstn <= 1'b0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        rdc(32'h9C, 32'h0);
        rdc(32'hA0, 32'h0);
        rdc(32'hA4, 32'h0);
        rdc(32'h10, 32'h0);
        pins(2'h0);
        tally_and_finish();
    end
endmodule : input_signal_loss_monitor_test
bind input_signal_loss_monitor ism_properties #(.CLK_ABSENT_CYC(CLK_ABSENT_CYC)) u_props (
    .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .input_clock_pair(input_clock_pair),
    .signal_missing_indicator(signal_missing_indicator));
`default_nettype wire

// >>> tb/ism_link_model.sv
`timescale 1ns/1ns
`default_nettype none
module ism_link_model (
    input  wire logic       run_clk,
    input  wire logic [4:0] run_lanes,
    output logic            link_clk,
    output logic [4:0]      lanes
);
    // 32 ns link clock, still while stopped; running lanes toggle
    initial begin
        link_clk = 1'b0;
        lanes = 5'h00;
        #7;
        forever begin
            #16;
            link_clk = run_clk ? ~link_clk : link_clk;
            lanes = lanes ^ run_lanes;
        end
    end
endmodule : ism_link_model
`default_nettype wire

// >>> tb/ism_properties.sv
`timescale 1ns/1ns
`default_nettype none
module ism_properties #(
    parameter int CLK_ABSENT_CYC = 16
) (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    input wire logic        input_clock_pair,
    input wire logic        signal_missing_indicator
);
    ism_pkg::addr_phase_t aph_q;
    logic [1:0]           ovr_q;
    logic                 prev_q;
    logic [7:0]           still_q;
    // address decode of the taken phase
    wire take = hsel && htrans[1] && hready;
    wire rd_mask = take && !hwrite && haddr[9:0] == 10'h09C;
    wire rd_stat = take && !hwrite && haddr[9:0] == 10'h0A4;
    // override shadow and link clock idle count
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            aph_q <= '0;
            ovr_q <= 2'h0;
            prev_q <= 1'b0;
            still_q <= 8'h00;
        end else begin
            aph_q <= '{valid: take, write: hwrite, addr: haddr[9:0]};
            if (aph_q.valid && aph_q.write && aph_q.addr == 10'h0A0) begin
                ovr_q <= hwdata[1:0];
            end
            prev_q <= input_clock_pair;
            still_q <= (input_clock_pair != prev_q) ? 8'h00
                     : (still_q == 8'hFF ? still_q : still_q + 8'h01);
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("bad response");
    property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_wr_fast; take && hwrite |=> hreadyout; endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
    property p_force_hi; ovr_q[0] && $past(ovr_q[0]) |=> signal_missing_indicator; endproperty
    a_force_hi: assert property (p_force_hi) else $error("not forced high");
    property p_force_lo; ovr_q == 2'h2 [*2] |=> !signal_missing_indicator; endproperty
    a_force_lo: assert property (p_force_lo) else $error("not forced low");
    property p_clk_gone;
        still_q > CLK_ABSENT_CYC + 6 && ovr_q == 2'h0 && $past(ovr_q) == 2'h0
            |-> signal_missing_indicator;
    endproperty
    a_clk_gone: assert property (p_clk_gone) else $error("clock loss missed");
    property p_mask_top; rd_mask |-> ##2 hrdata[31:5] == 27'h0; endproperty
    a_mask_top: assert property (p_mask_top) else $error("mask top bits set");
    property p_stat_top; rd_stat |-> ##2 hrdata[31:6] == 26'h0; endproperty
    a_stat_top: assert property (p_stat_top) else $error("status top bits set");
    property p_stat_hi; rd_stat && ovr_q[0] |-> ##2 hrdata[5:0] == 6'h3F; endproperty
    a_stat_hi: assert property (p_stat_hi) else $error("forced status wrong");
endmodule : ism_properties
`default_nettype wire
